/* File: pcc_map.vh */
`ifndef PCC_MAP_VH
`define PCC_MAP_VH

// Control register placement on the special function bus
`define PCC_CTRL_ADDR 8'hd7
`define PCC_CTRL_RESET 8'h53

// Control register fields
`define PCC_OSC_HALT_BIT 7
`define PCC_LOCK_BIT 6
`define PCC_RSVD_HI 5
`define PCC_RSVD_LO 4
`define PCC_FAST_IRQ_BIT 3
`define PCC_DIV_HI 2
`define PCC_DIV_LO 0

// Reset values of the stored fields
`define PCC_OSC_HALT_RST 1'h0
`define PCC_LOCK_RST 1'h1
`define PCC_RSVD_RST 2'h1
`define PCC_FAST_IRQ_RST 1'h0
`define PCC_DIV_RST 3'h3

// Loop ratio and lock qualification
`define PCC_LOOP_RATIO 512
`define PCC_LOCK_TOL 8
`define PCC_LOCK_PERIODS 4
`define PCC_FREQ_TOL_PCT 20

`endif

/* File: pcc_clock_control.v */
// Summary of operation
// - Loop runs at 512 times crystal reference
// - Core runs at loop rate or binary divisions
// - Default core clock is loop divided by 8
// - Modulator tick at crystal rate, core synchronous
// - Divider field bits [2:0] selects core rate
// - Bit 7 halts crystal oscillator in power-down
// - Bit 6 read-only lock flag from power-on
// - Unlocked loop may free-run within 20 percent
// - Crystal lost after lock rails, core halts
// - Fast-interrupt bit runs interrupts at full rate
// - Interrupt return restores divider-selected rate
// - Core rate is loop over two to field
`timescale 1ns/10ps
`default_nettype none
`include "pcc_map.vh"

module pcc_clock_control #(
    parameter RATIO = `PCC_LOOP_RATIO,
    parameter LOCK_TOL = `PCC_LOCK_TOL,
    parameter LOCK_PERIODS = `PCC_LOCK_PERIODS
) (
    // Clock and reset; mclk stands for the loop output clock
    input wire mclk,
    input wire reset_n,
    // Special function register access
    input wire [7:0] sfrAddr,
    input wire sfrWrite,
    input wire [7:0] sfrWdata,
    output reg [7:0] sfrRdata,
    // Crystal reference and oscillator control
    input wire xtalRef,
    input wire powerDown,
    output reg oscEnable,
    // Interrupt entry and return from the core
    input wire irqEnter,
    input wire irqReturn,
    // Generated timing
    output reg coreTick,
    output reg modulatorTick,
    output reg [2:0] coreRate,
    output reg loopRailed
);

    localparam CW = 9;
    localparam PW = 12;
    localparam integer MISS = 2 * RATIO;
    localparam [PW-1:0] RATIO_W = RATIO[PW-1:0];
    localparam [PW-1:0] TOL_W = LOCK_TOL[PW-1:0];
    localparam [PW-1:0] MISS_W = MISS[PW-1:0];
    localparam [2:0] GOOD_W = LOCK_PERIODS[2:0];

    // Lock qualification states
    localparam [2:0] ST_QUAL = 3'h1;
    localparam [2:0] ST_LOCKED = 3'h2;
    localparam [2:0] ST_FREE = 3'h4;

    reg oscHalt_r;
    reg [1:0] rsvd_r;
    reg fastIrq_r;
    reg [2:0] divSel_r;
    reg lock_r;
    reg fastActive_r;
    reg [2:0] rate_r;
    reg [CW-1:0] cnt_r;
    reg refPrev_r;
    reg [PW-1:0] period_r;
    reg [2:0] good_r;
    reg [2:0] state_r;
    reg railed_r;
    reg armed_r;
    reg [2:0] rateTarget;
    reg boundary;
    wire refRise;
    wire ctrlHit;
    wire ctrlWrite;
    wire [7:0] tapEnd;

    // Boundary of a core cycle at the given rate code
    function cycleEnd;
        input [2:0] code;
        input [CW-1:0] cnt;
        reg [CW-1:0] mask;
        begin
            mask = ~({CW{1'b1}} << code);
            cycleEnd = ((cnt & mask) == mask);
        end
    endfunction

    // Measured reference period inside the lock window
    function periodOk;
        input [PW-1:0] per;
        reg [PW-1:0] len;
        begin
            len = per + 12'h001;
            periodOk = (len + TOL_W >= RATIO_W) && (len <= RATIO_W + TOL_W);
        end
    endfunction

    // One cycle-end decode per rate code; the running rate picks one
    genvar k;
    generate
        for (k = 0; k < 8; k = k + 1) begin : gTap
            localparam integer KI = k;
            localparam [2:0] CODE = KI[2:0];
            assign tapEnd[k] = cycleEnd(CODE, cnt_r);
        end
    endgenerate

    assign ctrlHit = (sfrAddr == `PCC_CTRL_ADDR);
    assign ctrlWrite = sfrWrite & ctrlHit;
    assign refRise = xtalRef & ~refPrev_r;

    // Control register writes; lock bit is not writable
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            oscHalt_r <= `PCC_OSC_HALT_RST;
        end else if (ctrlWrite) begin
            oscHalt_r <= sfrWdata[`PCC_OSC_HALT_BIT];
        end
    end

    // Reserved pair is stored and read back as written
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            rsvd_r <= `PCC_RSVD_RST;
        end else if (ctrlWrite) begin
            rsvd_r <= sfrWdata[`PCC_RSVD_HI:`PCC_RSVD_LO];
        end
    end

    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            fastIrq_r <= `PCC_FAST_IRQ_RST;
        end else if (ctrlWrite) begin
            fastIrq_r <= sfrWdata[`PCC_FAST_IRQ_BIT];
        end
    end

    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            divSel_r <= `PCC_DIV_RST;
        end else if (ctrlWrite) begin
            divSel_r <= sfrWdata[`PCC_DIV_HI:`PCC_DIV_LO];
        end
    end

    // Registered read; unmapped addresses return zero
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            sfrRdata <= 8'h00;
        end else if (ctrlHit) begin
            sfrRdata <= {oscHalt_r, lock_r, rsvd_r, fastIrq_r, divSel_r};
        end else begin
            sfrRdata <= 8'h00;
        end
    end

    // Oscillator stops only in power-down with halt selected
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            oscEnable <= 1'b1;
        end else begin
            oscEnable <= ~(powerDown & oscHalt_r);
        end
    end

    // High at reset so a crystal already high is not taken as an edge
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            refPrev_r <= 1'b1;
        end else begin
            refPrev_r <= xtalRef;
        end
    end

    // Reference period measured in loop cycles
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            period_r <= {PW{1'b0}};
        end else if (refRise) begin
            period_r <= {PW{1'b0}};
        end else if (period_r != {PW{1'b1}}) begin
            period_r <= period_r + 12'h001;
        end
    end

    // Lock decided once after power-on, then only watched for loss
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            state_r <= ST_QUAL;
            good_r <= 3'h0;
            armed_r <= 1'b0;
            lock_r <= `PCC_LOCK_RST;
            railed_r <= 1'b0;
        end else begin
            case (state_r)
                ST_QUAL: begin
                    if (period_r >= MISS_W) begin
                        // No crystal: loop free-runs near nominal
                        lock_r <= 1'b0;
                        state_r <= ST_FREE;
                    end else if (refRise && !armed_r) begin
                        // First edge only opens the first whole period
                        armed_r <= 1'b1;
                    end else if (refRise) begin
                        if (periodOk(period_r)) begin
                            if (good_r + 3'h1 >= GOOD_W) begin
                                lock_r <= 1'b1;
                                state_r <= ST_LOCKED;
                            end
                            good_r <= good_r + 3'h1;
                        end else begin
                            lock_r <= 1'b0;
                            state_r <= ST_FREE;
                        end
                    end
                end
                ST_LOCKED: begin
                    // Sticky: a railed loop leaves nothing to recover with
                    if (period_r >= MISS_W) begin
                        railed_r <= 1'b1;
                    end
                end
                ST_FREE: begin
                    lock_r <= 1'b0;
                end
                default: begin
                    state_r <= ST_QUAL;
                end
            endcase
        end
    end

    // Fast-interrupt mode spans one serviced interrupt
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            fastActive_r <= 1'b0;
        end else if (irqEnter && fastIrq_r) begin
            fastActive_r <= 1'b1;
        end else if (irqReturn) begin
            fastActive_r <= 1'b0;
        end
    end

    always @* begin
        if (fastActive_r) begin
            rateTarget = 3'h0;
        end else begin
            rateTarget = divSel_r;
        end
    end

    // Cycle end of the rate now running
    always @* begin
        boundary = tapEnd[rate_r];
    end

    // Free counter shared by core and modulator keeps them in step
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            cnt_r <= {CW{1'b0}};
            modulatorTick <= 1'b0;
        end else begin
            cnt_r <= cnt_r + 9'h001;
            modulatorTick <= (cnt_r == {CW{1'b1}});
        end
    end

    // Only a finished core cycle may change rate, so no runt
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            rate_r <= `PCC_DIV_RST;
        end else if (boundary) begin
            rate_r <= rateTarget;
        end
    end

    // Core tick stops for good once the loop has railed
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            coreTick <= 1'b0;
        end else begin
            coreTick <= boundary & ~railed_r;
        end
    end

    // Status copies lag the internal state by one cycle
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            coreRate <= `PCC_DIV_RST;
            loopRailed <= 1'b0;
        end else begin
            coreRate <= rate_r;
            loopRailed <= railed_r;
        end
    end

endmodule

`default_nettype wire

/* File: pcc_clock_control_sva.sv */
`timescale 1ns/10ps
`default_nettype none
module pcc_clock_control_sva (
    // Clock, reset, bus
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic [7:0] sfrAddr,
    input wire logic sfrWrite,
    input wire logic [7:0] sfrWdata,
    input wire logic [7:0] sfrRdata,
    // Timing and control
    input wire logic xtalRef,
    input wire logic powerDown,
    input wire logic oscEnable,
    input wire logic irqEnter,
    input wire logic irqReturn,
    input wire logic coreTick,
    input wire logic modulatorTick,
    input wire logic [2:0] coreRate,
    input wire logic loopRailed
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!reset_n);
    AST_RAIL_QUIET: assert property (loopRailed |-> !coreTick)
        else $error("tick while railed");
    AST_RAIL_HOLD: assert property (loopRailed |=> loopRailed)
        else $error("rail dropped");
    AST_RAIL_LOCK: assert property (loopRailed && sfrAddr == 8'hd7 |=> sfrRdata[6])
        else $error("railed without lock");
    AST_OSC_RUN: assert property (!powerDown |=> oscEnable)
        else $error("oscillator off while awake");
    AST_READ_ZERO: assert property (sfrAddr != 8'hd7 |=> sfrRdata == 8'h00)
        else $error("unmapped read not zero");
    AST_WRITE_BACK: assert property ((sfrWrite && sfrAddr == 8'hd7) ##1
        (sfrAddr == 8'hd7 && !sfrWrite) |=> {sfrRdata[7], sfrRdata[5:0]} ==
        {$past(sfrWdata[7], 2), $past(sfrWdata[5:0], 2)}) else $error("readback");
    AST_FULL_RATE: assert property ((coreRate == 3'h0 && !loopRailed) [*4] |-> coreTick)
        else $error("full rate gap");
    AST_MOD_GAP: assert property (modulatorTick |-> ##[512:512] modulatorTick)
        else $error("modulator spacing");
    AST_RATE_SWITCH: assert property (!loopRailed && !$stable(coreRate) |-> $past(coreTick))
        else $error("rate switched inside a core cycle");
    cover property (sfrAddr == 8'hd7 ##2 !sfrRdata[6]);
    cover property (irqEnter ##[1:20] coreRate == 3'h0);
    cover property (loopRailed);
    cover property (coreTick && coreRate == 3'h7);
endmodule
`default_nettype wire

/* File: pcc_xtal_model.sv */
`timescale 1ns/10ps
`default_nettype none
module pcc_xtal_model #(parameter int HALF = 256) (
    // Loop clock and crystal state
    input wire logic mclk,
    input wire logic running,
    // Reference out
    output logic xtalRef
);
    int cnt = 0;
    initial xtalRef = 1'b0;
    // Halted or missing crystal simply stops toggling
    always @(posedge mclk) begin
        if (running && cnt == HALF - 1) begin
            cnt <= 0;
            xtalRef <= ~xtalRef;
        end else if (running) begin
            cnt <= cnt + 1;
        end
    end
endmodule
`default_nettype wire

/* File: test_pcc_clock_control.sv */
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin failCount++; \
    $display("wrong value at %0t: got %0h want %0h", $time, a, e); end end
module test_pcc_clock_control;
    logic mclk = 0, reset_n = 0, sfrWrite = 0, powerDown = 0, irqEnter = 0, irqReturn = 0;
    logic present = 1;
    logic [7:0] sfrAddr = 8'h00, sfrWdata = 8'h00, sfrRdata, rv;
    logic xtalRef, oscEnable, coreTick, modulatorTick, loopRailed;
    logic [2:0] coreRate;
    int failCount = 0, checks = 0, p;
    pcc_clock_control uut (.mclk(mclk), .reset_n(reset_n), .sfrAddr(sfrAddr),
        .sfrWrite(sfrWrite), .sfrWdata(sfrWdata), .sfrRdata(sfrRdata), .xtalRef(xtalRef),
        .powerDown(powerDown), .oscEnable(oscEnable), .irqEnter(irqEnter),
        .irqReturn(irqReturn), .coreTick(coreTick), .modulatorTick(modulatorTick),
        .coreRate(coreRate), .loopRailed(loopRailed));
    pcc_xtal_model xtal (.mclk(mclk), .running(present && oscEnable), .xtalRef(xtalRef));
    initial forever #5 mclk = ~mclk;
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk) begin sfrAddr <= a; sfrWrite <= 1'b1; sfrWdata <= d; end
        @(posedge mclk) sfrWrite <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge mclk) sfrAddr <= a;
        repeat (2) @(posedge mclk);
        #1 rv = sfrRdata;
    endtask
    task automatic irq(input bit ret);
        @(posedge mclk) begin irqEnter <= !ret; irqReturn <= ret; end
        @(posedge mclk) begin irqEnter <= 1'b0; irqReturn <= 1'b0; end
    endtask
    task automatic waitRate(input logic [2:0] r);
        for (int i = 0; i < 300 && coreRate !== r; i++) @(posedge mclk);
    endtask
    // Gap between two pulses, bounded so a dead output cannot hang the run
    task automatic gap(input bit mod);
        @(posedge mclk);
        p = 0;
        while ((mod ? modulatorTick : coreTick) !== 1'b1 && p < 600) begin @(posedge mclk); p++; end
        p = 0;
        do begin @(posedge mclk); p++; end while ((mod ? modulatorTick : coreTick) !== 1'b1 && p < 600);
    endtask
    task automatic tReset;
        rd(8'hd7);
        `CHK(rv, 8'h53)
        gap(0);
        `CHK(p, 8)
        $display("reset test done");
    endtask
    task automatic tDivide;
        for (int c = 0; c < 8; c++) begin
            wr(8'hd7, 8'h10 | 8'(c));
            waitRate(3'(c));
            `CHK(coreRate, 3'(c))
            gap(0);
            `CHK(p, 1 << c)
        end
        $display("divider test done");
    endtask
    task automatic tReg;
        wr(8'hd7, 8'h00);
        rd(8'hd7);
        `CHK(rv, 8'h40)
        wr(8'h00, 8'hff);
        rd(8'hd7);
        `CHK(rv, 8'h40)
        rd(8'h00);
        `CHK(rv, 8'h00)
        $display("register test done");
    endtask
    task automatic tFast;
        wr(8'hd7, 8'h0b);
        waitRate(3'h3);
        irq(0);
        waitRate(3'h0);
        `CHK(coreRate, 3'h0)
        irq(1);
        waitRate(3'h3);
        `CHK(coreRate, 3'h3)
        wr(8'hd7, 8'h03);
        irq(0);
        repeat (20) @(posedge mclk);
        `CHK(coreRate, 3'h3)
        irq(1);
        $display("fast interrupt test done");
    endtask
    task automatic tOsc;
        gap(1);
        `CHK(p, 512)
        wr(8'hd7, 8'h83);
        powerDown <= 1'b1;
        repeat (3) @(posedge mclk);
        `CHK(oscEnable, 1'b0)
        wr(8'hd7, 8'h03);
        repeat (3) @(posedge mclk);
        `CHK(oscEnable, 1'b1)
        powerDown <= 1'b0;
        $display("oscillator test done");
    endtask
    task automatic tRail;
        rd(8'hd7);
        `CHK(rv[6], 1'b1)
        @(posedge mclk) present <= 1'b0;
        repeat (1600) @(posedge mclk);
        `CHK(loopRailed, 1'b1)
        repeat (40) @(posedge mclk) `CHK(coreTick, 1'b0)
        $display("rail test done");
    endtask
    // Mid-run reset with no crystal: lock clears, core keeps default rate
    task automatic tNoXtal;
        @(posedge mclk) reset_n <= 1'b0;
        repeat (12) @(posedge mclk);
        reset_n <= 1'b1;
        repeat (1100) @(posedge mclk);
        `CHK(loopRailed, 1'b0)
        rd(8'hd7);
        `CHK(rv, 8'h13)
        gap(0);
        `CHK(p, 8)
        $display("no crystal test done");
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", checks, failCount);
        if (failCount == 0 && checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        repeat (40000) @(posedge mclk);
        failCount++;
        results;
    end
    initial begin
        repeat (12) @(posedge mclk);
        reset_n <= 1'b1;
        tReset;
        tDivide;
        tReg;
        tFast;
        repeat (2500) @(posedge mclk);
        tOsc;
        tRail;
        tNoXtal;
        results;
    end
endmodule
bind pcc_clock_control pcc_clock_control_sva chk (.mclk(mclk), .reset_n(reset_n),
    .sfrAddr(sfrAddr), .sfrWrite(sfrWrite), .sfrWdata(sfrWdata), .sfrRdata(sfrRdata),
    .xtalRef(xtalRef), .powerDown(powerDown), .oscEnable(oscEnable), .irqEnter(irqEnter),
    .irqReturn(irqReturn), .coreTick(coreTick), .modulatorTick(modulatorTick),
    .coreRate(coreRate), .loopRailed(loopRailed));
`default_nettype wire
